//--- logic/slow_path_packet_port.sv
`timescale 1ns/1ps
`include "slow_path_map.svh"
module slow_path_packet_port
    import slow_path_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_byte_en,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic [63:0] outbound_word_data,
    output logic outbound_word_valid,
    input wire logic outbound_word_ready,
    output logic outbound_final_word,
    output logic [7:0] outbound_byte_keep,
    input wire logic [63:0] inbound_word_data,
    input wire logic inbound_word_valid,
    input wire logic inbound_final_word,
    output logic tx_engine_busy
);
    // =====================================================================
    // Storage
    logic [63:0] tx_first_word;
    logic [63:0] tx_next_word;
    logic [63:0] rx_packet_buffer [512];
    port_state_t st_ff;
    port_state_t nxt_st;
    end_addr_fifo_if fifo ();

    end_address_fifo end_address_fifo_inst (
        .clk(clk),
        .rst(rst),
        .fifo(fifo)
    );

    logic [1:0] region;
    logic [9:0] tx_buffer_write_address;
    logic [9:0] rx_buffer_read_address;
    assign region = reg_addr[11:10];
    assign tx_buffer_write_address = reg_addr[9:0];
    assign rx_buffer_read_address = reg_addr[9:0];

    // Entry takes two CPU words, even address low; one array per lane keeps a single writer each.
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_tx_lane
            logic [7:0] tx_packet_buffer [512];
            always_ff @(posedge clk) begin
                if (reg_write && region == `REGION_TX_BUFFER && tx_buffer_write_address[0] == 1'(b / 4)
                        && reg_byte_en[b % 4]) begin
                    tx_packet_buffer[tx_buffer_write_address[9:1]] <= reg_wdata[(b % 4) * 8 +: 8];
                end
            end
            assign tx_first_word[b * 8 +: 8] = tx_packet_buffer[9'h000];
            assign tx_next_word[b * 8 +: 8] = tx_packet_buffer[st_ff.rd_ptr];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (st_ff.wr_strobe) begin
            rx_packet_buffer[st_ff.wr_addr] <= st_ff.wr_data;
        end
    end

    // =====================================================================
    // Helpers
    function automatic logic [7:0] decode_keep(input logic [2:0] rem);
        logic [7:0] m;
        m = `KEEP_ALL;
        if (rem != 3'h0) begin
            m = `KEEP_ALL >> (4'h8 - {1'b0, rem});
        end
        return m;
    endfunction

    function automatic logic word_matches(input int k, input logic [63:0] d, input logic [303:0] hdr,
            input logic [37:0] msk);
        logic ok;
        int idx;
        ok = 1'b1;
        for (int j = 0; j < 8; j++) begin
            idx = k * 8 + j;
            if (idx < `HEADER_BYTES) begin
                if (msk[idx] && d[j * 8 +: 8] != hdr[idx * 8 +: 8]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    // =====================================================================
    // Next state
    logic start_seen;
    logic done_seen;
    logic accepted;
    logic sop;
    logic in_window;
    int word_idx;
    logic [9:0] words;
    logic word_ok;
    logic header_match_ok;
    logic [8:0] end_addr;

    always_comb begin
        nxt_st = st_ff;
        start_seen = st_ff.req_s2 != st_ff.req_s3;
        done_seen = st_ff.done_s2 != st_ff.done_s3;
        accepted = st_ff.out_valid && outbound_word_ready;
        sop = inbound_word_valid && !st_ff.in_packet;
        in_window = 1'b0;
        word_idx = 0;
        words = 10'(st_ff.length[11:3]) + 10'(|st_ff.length[2:0]);
        word_ok = 1'b1;
        header_match_ok = st_ff.match;
        end_addr = st_ff.wr_ptr;
        nxt_st.pop = 1'b0;
        nxt_st.push = 1'b0;
        nxt_st.wr_strobe = 1'b0;
        nxt_st.rdata = 32'h0000_0000;

        // Register writes.
        if (reg_write && region == `REGION_CONTROL) begin
            case (reg_addr)
                `REG_TX_CONTROL: begin
                    // A request while busy is ignored; firmware checks busy first.
                    if (reg_wdata[`TX_REQUEST_BIT] && !st_ff.busy) begin
                        nxt_st.length = reg_wdata[11:0];
                        nxt_st.busy = 1'b1;
                        nxt_st.req_tog = !st_ff.req_tog;
                    end
                end
                `REG_RX_CONTROL: nxt_st.rx_en = reg_wdata[`RX_ENABLE_BIT];
                `REG_FIFO_HEAD: nxt_st.pop = 1'b1;
                `REG_MASK_LOW: nxt_st.mask[31:0] = reg_wdata;
                `REG_MASK_HIGH: nxt_st.mask[37:32] = reg_wdata[5:0];
                default: begin
                    if (reg_addr >= `REG_HEADER_BASE && reg_addr <= `REG_HEADER_LAST) begin
                        nxt_st.header[(reg_addr - `REG_HEADER_BASE) * 32 +: 32] = reg_wdata;
                    end
                end
            endcase
        end

        // Register reads; data stands in the next cycle only.
        if (reg_read) begin
            case (region)
                `REGION_CONTROL: begin
                    case (reg_addr)
                        `REG_TX_CONTROL: nxt_st.rdata = {20'h0_0000, st_ff.length};
                        `REG_STATUS: begin
                            nxt_st.rdata[`STATUS_BUSY_BIT] = st_ff.busy;
                            nxt_st.rdata[`STATUS_EMPTY_BIT] = fifo.empty;
                            nxt_st.rdata[`STATUS_COUNT_LSB +: 5] = fifo.count;
                        end
                        `REG_RX_CONTROL: nxt_st.rdata[`RX_ENABLE_BIT] = st_ff.rx_en;
                        `REG_FIFO_HEAD: nxt_st.rdata = {23'h00_0000, fifo.head};
                        `REG_MASK_LOW: nxt_st.rdata = st_ff.mask[31:0];
                        `REG_MASK_HIGH: nxt_st.rdata = {26'h000_0000, st_ff.mask[37:32]};
                        default: begin
                            if (reg_addr >= `REG_HEADER_BASE && reg_addr <= `REG_HEADER_LAST) begin
                                nxt_st.rdata = 32'({16'h0000, st_ff.header} >> ((reg_addr - `REG_HEADER_BASE) * 32));
                            end
                        end
                    endcase
                end
                `REGION_RX_BUFFER: nxt_st.rdata = reg_addr[0] ? rx_packet_buffer[rx_buffer_read_address[9:1]][63:32]
                    : rx_packet_buffer[rx_buffer_read_address[9:1]][31:0];
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end

        // Crossing stages for request and done toggles.
        nxt_st.req_s1 = st_ff.req_tog;
        nxt_st.req_s2 = st_ff.req_s1;
        nxt_st.req_s3 = st_ff.req_s2;
        nxt_st.done_s1 = st_ff.done_tog;
        nxt_st.done_s2 = st_ff.done_s1;
        nxt_st.done_s3 = st_ff.done_s2;
        if (done_seen) begin
            nxt_st.busy = 1'b0;
        end

        // Transmit engine.
        case (st_ff.tx_state)
            TX_IDLE: begin
                if (start_seen) begin
                    nxt_st.final_mask = decode_keep(st_ff.length[2:0]);
                    if (words == 10'h000) begin
                        // Nothing to send: report done at once so busy does not stick.
                        nxt_st.done_tog = !st_ff.done_tog;
                    end else begin
                        nxt_st.tx_state = TX_SEND;
                        nxt_st.out_valid = 1'b1;
                        nxt_st.out_data = tx_first_word;
                        nxt_st.rd_ptr = 9'h001;
                        nxt_st.remaining = words;
                        nxt_st.out_last = (words == 10'h001);
                        nxt_st.out_keep = (words == 10'h001) ? decode_keep(st_ff.length[2:0]) : `KEEP_ALL;
                    end
                end
            end
            TX_SEND: begin
                // Without an accept every output keeps its value.
                if (accepted) begin
                    if (st_ff.remaining == 10'h001) begin
                        nxt_st.out_valid = 1'b0;
                        nxt_st.out_last = 1'b0;
                        nxt_st.tx_state = TX_IDLE;
                        nxt_st.done_tog = !st_ff.done_tog;
                    end else begin
                        nxt_st.out_data = tx_next_word;
                        nxt_st.rd_ptr = st_ff.rd_ptr + 9'h001;
                        nxt_st.remaining = st_ff.remaining - 10'h001;
                        nxt_st.out_last = (st_ff.remaining == 10'h002);
                        nxt_st.out_keep = (st_ff.remaining == 10'h002) ? st_ff.final_mask : `KEEP_ALL;
                    end
                end
            end
            default: nxt_st.tx_state = TX_IDLE;
        endcase

        // Header, mask and enable pass two stages before the receive path uses them.
        nxt_st.en_s1 = st_ff.rx_en;
        nxt_st.en_s2 = st_ff.en_s1;
        nxt_st.mask_s1 = st_ff.mask;
        nxt_st.mask_s2 = st_ff.mask_s1;
        nxt_st.header_s1 = st_ff.header;
        nxt_st.header_s2 = st_ff.header_s1;

        // Receive path.
        if (inbound_word_valid) begin
            if (sop) begin
                in_window = 1'b1;
                word_idx = 0;
                header_match_ok = 1'b1;
                end_addr = st_ff.last_good;
                nxt_st.phase = 5'b0_0010;
            end else begin
                for (int k = 1; k < `HEADER_WORDS; k++) begin
                    if (st_ff.phase[k]) begin
                        in_window = 1'b1;
                        word_idx = k;
                    end
                end
                nxt_st.phase = {st_ff.phase[3:0], 1'b0};
            end
            if (in_window) begin
                word_ok = word_matches(word_idx, inbound_word_data, st_ff.header_s2, st_ff.mask_s2);
                header_match_ok = header_match_ok && word_ok;
            end
            nxt_st.match = header_match_ok;
            nxt_st.wr_strobe = 1'b1;
            nxt_st.wr_addr = end_addr;
            nxt_st.wr_data = inbound_word_data;
            nxt_st.wr_ptr = end_addr + 9'h001;
            nxt_st.in_packet = !inbound_final_word;
            if (inbound_final_word) begin
                nxt_st.phase = 5'b0_0000;
                if (st_ff.en_s2 && !fifo.count[`FIFO_FULL_BIT] && header_match_ok) begin
                    nxt_st.push = 1'b1;
                    nxt_st.push_addr = end_addr + 9'h001;
                    nxt_st.last_good = end_addr + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.tx_state <= TX_IDLE;
            st_ff.length <= `LENGTH_RESET;
            st_ff.mask <= `MASK_RESET;
            st_ff.out_keep <= `KEEP_ALL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // Outputs
    assign fifo.push = st_ff.push;
    assign fifo.push_data = st_ff.push_addr;
    assign fifo.pop = st_ff.pop;
    assign reg_rdata = st_ff.rdata;
    assign outbound_word_data = st_ff.out_data;
    assign outbound_word_valid = st_ff.out_valid;
    assign outbound_final_word = st_ff.out_last;
    assign outbound_byte_keep = st_ff.out_keep;
    assign tx_engine_busy = st_ff.busy;
endmodule

//--- logic/slow_path_map.svh
// Summary of operation
// - Transmit buffer holds 1024 CPU words of 32 bits, read 64 bits toward MAC.
// - Transmit buffer writes honour per-byte write enables.
// - Send request crosses through a synchronizer; busy rises and length is captured.
// - Word count is length bits 11..3, plus one when bytes remain.
// - Length bits 2..0 decode into the final word byte-keep mask.
// - Start flag reads first word, raises valid; accepts advance pointer and counter.
// - Ready low holds outbound word and control outputs unchanged.
// - Counter at one gives last flag and final keep; earlier words keep all.
// - Final accept raises done flag, synchronized back to clear busy.
// - Receive buffer holds 512 words of 64 bits, read 32 bits by CPU.
// - Packet start triggers header compare of bytes 0..37 over five cycles.
// - A 38-bit mask selects compared bytes; all zero disables checking.
// - Accept needs enable, fill count bit 4 clear, header match; push end address.
// - Every packet is stored from the last good end address.
// - Each valid inbound word strobes a buffer write and advances the pointer.
// - End-address queue holds sixteen entries; packets should stay within 256 bytes.
// - Receive buffer is read by the CPU through a simple memory port.
`ifndef SLOW_PATH_MAP_SVH
`define SLOW_PATH_MAP_SVH

// =====================================================================
// Register word addresses and address regions
`define REG_TX_CONTROL 12'h000
`define REG_STATUS 12'h001
`define REG_RX_CONTROL 12'h002
`define REG_FIFO_HEAD 12'h003
`define REG_MASK_LOW 12'h004
`define REG_MASK_HIGH 12'h005
`define REG_HEADER_BASE 12'h008
`define REG_HEADER_LAST 12'h011
`define REGION_CONTROL 2'h0
`define REGION_TX_BUFFER 2'h1
`define REGION_RX_BUFFER 2'h2

// =====================================================================
// Field positions
`define TX_REQUEST_BIT 31
`define STATUS_BUSY_BIT 0
`define STATUS_EMPTY_BIT 1
`define STATUS_COUNT_LSB 8
`define RX_ENABLE_BIT 0
`define FIFO_FULL_BIT 4

// =====================================================================
// Reset values and constants
`define LENGTH_RESET 12'h000
`define MASK_RESET 38'h00_0000_0000
`define KEEP_ALL 8'hff
`define HEADER_BYTES 38
`define HEADER_WORDS 5

`endif

//--- logic/slow_path_pkg.sv
package slow_path_pkg;

    typedef enum logic {
        TX_IDLE,
        TX_SEND
    } tx_state_t;

    typedef struct packed {
        logic busy;
        logic [11:0] length;
        logic req_tog;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        tx_state_t tx_state;
        logic [8:0] rd_ptr;
        logic [9:0] remaining;
        logic [7:0] final_mask;
        logic out_valid;
        logic [63:0] out_data;
        logic out_last;
        logic [7:0] out_keep;
        logic done_tog;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic rx_en;
        logic [37:0] mask;
        logic [303:0] header;
        logic en_s1;
        logic en_s2;
        logic [37:0] mask_s1;
        logic [37:0] mask_s2;
        logic [303:0] header_s1;
        logic [303:0] header_s2;
        logic in_packet;
        logic [4:0] phase;
        logic match;
        logic [8:0] wr_ptr;
        logic [8:0] last_good;
        logic wr_strobe;
        logic [8:0] wr_addr;
        logic [63:0] wr_data;
        logic push;
        logic [8:0] push_addr;
        logic pop;
        logic [31:0] rdata;
    } port_state_t;

    typedef struct packed {
        logic [3:0] rd;
        logic [3:0] wr;
        logic [4:0] count;
    } fifo_state_t;

endpackage

//--- logic/end_addr_fifo_if.sv
`timescale 1ns/1ps
interface end_addr_fifo_if;
    logic push;
    logic [8:0] push_data;
    logic pop;
    logic [8:0] head;
    logic empty;
    logic [4:0] count;

    modport owner (output push, output push_data, output pop, input head, input empty, input count);
    modport store (input push, input push_data, input pop, output head, output empty, output count);
endinterface

//--- logic/end_address_fifo.sv
`timescale 1ns/1ps
module end_address_fifo
    import slow_path_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    end_addr_fifo_if.store fifo
);
    logic [8:0] mem [16];
    fifo_state_t st_ff;
    fifo_state_t nxt_st;
    logic do_push;
    logic do_pop;

    // A push into a full queue is dropped; the owner gates on the count.
    assign do_push = fifo.push && !st_ff.count[4];
    assign do_pop = fifo.pop && (st_ff.count != 5'h00);

    always_comb begin
        nxt_st = st_ff;
        if (do_push) begin
            nxt_st.wr = st_ff.wr + 4'h1;
        end
        if (do_pop) begin
            nxt_st.rd = st_ff.rd + 4'h1;
        end
        case ({do_push, do_pop})
            2'b10: nxt_st.count = st_ff.count + 5'h01;
            2'b01: nxt_st.count = st_ff.count - 5'h01;
            default: nxt_st.count = st_ff.count;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[st_ff.wr] <= fifo.push_data;
        end
    end

    // Fall-through head: valid whenever the queue is not empty.
    assign fifo.head = mem[st_ff.rd];
    assign fifo.empty = (st_ff.count == 5'h00);
    assign fifo.count = st_ff.count;
endmodule

//--- tb/slow_path_packet_port_checker.sv
`timescale 1ns/1ps
module slow_path_packet_port_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_byte_en,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [63:0] outbound_word_data,
    input wire logic outbound_word_valid,
    input wire logic outbound_word_ready,
    input wire logic outbound_final_word,
    input wire logic [7:0] outbound_byte_keep,
    input wire logic [63:0] inbound_word_data,
    input wire logic inbound_word_valid,
    input wire logic inbound_final_word,
    input wire logic tx_engine_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // Transmit stream
    property p_hold;
        outbound_word_valid && !outbound_word_ready |=> outbound_word_valid && $stable(outbound_word_data)
            && $stable(outbound_final_word) && $stable(outbound_byte_keep);
    endproperty
    a_hold: assert property (p_hold) else $error("outbound word changed while stalled");
    property p_keep;
        outbound_word_valid && !outbound_final_word |-> outbound_byte_keep == 8'hff;
    endproperty
    a_keep: assert property (p_keep) else $error("early word without full keep");
    property p_last_valid;
        outbound_final_word |-> outbound_word_valid;
    endproperty
    a_last_valid: assert property (p_last_valid) else $error("final flag without valid");
    property p_stay;
        outbound_word_valid && !(outbound_word_ready && outbound_final_word) |=> outbound_word_valid;
    endproperty
    a_stay: assert property (p_stay) else $error("valid dropped before final accept");
    property p_valid_busy;
        outbound_word_valid |-> tx_engine_busy;
    endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("valid while not busy");
    property p_start;
        reg_write && reg_addr == 12'h000 && reg_wdata[31] && reg_wdata[11:0] != 12'h000 && !tx_engine_busy
            |=> tx_engine_busy ##[2:6] outbound_word_valid;
    endproperty
    a_start: assert property (p_start) else $error("send request did not start stream");
    property p_done;
        outbound_word_valid && outbound_word_ready && outbound_final_word |=> !outbound_word_valid ##[1:6]
            !tx_engine_busy;
    endproperty
    a_done: assert property (p_done) else $error("busy not cleared after final word");
    // ==========================================================
    // Register port
    property p_rdata;
        !reg_read |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside answer cycle");
    c_stall: cover property (outbound_word_valid && !outbound_word_ready);
    c_final: cover property (outbound_word_valid && outbound_word_ready && outbound_final_word);
    c_inbound_end: cover property (inbound_word_valid && inbound_final_word);
endmodule
bind slow_path_packet_port slow_path_packet_port_checker slow_path_packet_port_checker_inst (.clk, .rst,
    .reg_addr, .reg_wdata, .reg_byte_en, .reg_write, .reg_read, .reg_rdata, .outbound_word_data,
    .outbound_word_valid, .outbound_word_ready, .outbound_final_word, .outbound_byte_keep,
    .inbound_word_data, .inbound_word_valid, .inbound_final_word, .tx_engine_busy);

//--- tb/mac_stream_model.sv
`timescale 1ns/1ps
module mac_stream_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic [63:0] outbound_word_data,
    input wire logic outbound_word_valid,
    input wire logic outbound_final_word,
    input wire logic [7:0] outbound_byte_keep,
    output logic outbound_word_ready,
    output logic [63:0] inbound_word_data,
    output logic inbound_word_valid,
    output logic inbound_final_word
);
    logic [63:0] got_data [$];
    logic [7:0] got_keep [$];
    logic got_last [$];
    int cyc;
    initial begin
        cyc = 0;
        outbound_word_ready = 1'b1;
        inbound_word_data = 64'h0000_0000_0000_0000;
        inbound_word_valid = 1'b0;
        inbound_final_word = 1'b0;
    end
    // A stalling sink holds ready low two cycles in three to stress the hold path.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        outbound_word_ready <= !stall || (cyc % 3 == 0);
        if (outbound_word_valid && outbound_word_ready) begin
            got_data.push_back(outbound_word_data);
            got_keep.push_back(outbound_byte_keep);
            got_last.push_back(outbound_final_word);
        end
    end
    function automatic logic [63:0] pkt(input logic [7:0] id, input int w, input logic good);
        return {16'h0000, (w == 4 && good) ? 8'ha5 : 8'h00, 8'h00, id, w[7:0], 8'h00,
            (w == 0 && good) ? 8'h5a : 8'h00};
    endfunction
    // Five words carry the whole 38-byte header; idle data shows the inverse of the last word.
    task automatic send(input logic [7:0] id, input logic good);
        for (int w = 0; w < 5; w++) begin
            @(posedge clk);
            inbound_word_data <= pkt(id, w, good);
            inbound_word_valid <= 1'b1;
            inbound_final_word <= (w == 4);
        end
        @(posedge clk);
        inbound_word_valid <= 1'b0;
        inbound_final_word <= 1'b0;
        inbound_word_data <= ~inbound_word_data;
    endtask
endmodule

//--- tb/slow_path_packet_port_test.sv
`timescale 1ns/1ps
module slow_path_packet_port_test;
    logic clk, rst, reg_write, reg_read, stall;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [3:0] reg_byte_en;
    logic [63:0] outbound_word_data, inbound_word_data;
    logic outbound_word_valid, outbound_word_ready, outbound_final_word;
    logic inbound_word_valid, inbound_final_word, tx_engine_busy;
    logic [7:0] outbound_byte_keep;
    logic [8:0] ea;
    int n_fail, comparisons, cycles;
    slow_path_packet_port slow_path_packet_port_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_byte_en,
        .reg_write, .reg_read, .reg_rdata, .outbound_word_data, .outbound_word_valid, .outbound_word_ready,
        .outbound_final_word, .outbound_byte_keep, .inbound_word_data, .inbound_word_valid,
        .inbound_final_word, .tx_engine_busy);
    mac_stream_model mac_stream_model_inst (.clk, .stall, .outbound_word_data, .outbound_word_valid,
        .outbound_final_word, .outbound_byte_keep, .outbound_word_ready, .inbound_word_data,
        .inbound_word_valid, .inbound_final_word);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_byte_en <= be;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    function automatic logic [31:0] txw(input int a);
        return {16'ha5a5, a[15:0]};
    endfunction
    task automatic rx_send(input logic [7:0] id, input logic good);
        mac_stream_model_inst.send(id, good);
        repeat (3) @(posedge clk);
    endtask
    task automatic pop_check(input logic [8:0] exp);
        rd(12'h003);
        chk(rv, {23'h0, exp});
        wr(12'h003, 32'h0000_0000, 4'hf);
    endtask
    // ==========================================================
    // Scenarios
    task automatic test_reset();
        rd(12'h001);
        chk(rv, 32'h0000_0002);
        rd(12'h000);
        chk(rv, 32'h0000_0000);
        rd(12'hc05);
        chk(rv, 32'h0000_0000);
        $display("test_reset done");
    endtask
    task automatic test_tx();
        logic [11:0] lens [4] = '{12'd8, 12'd13, 12'd32, 12'd0};
        logic [63:0] e;
        int nw, k;
        for (int a = 0; a < 8; a++) wr(12'h400 + a, txw(a), 4'hf);
        wr(12'h400, 32'hffff_ffff, 4'b0010);
        foreach (lens[i]) begin
            stall <= (i == 1 || i == 2);
            wr(12'h000, {20'h8_0000, lens[i]}, 4'hf);
            #1 chk(tx_engine_busy, 1'b1);
            if (lens[i] != 12'd0) begin
                wr(12'h000, 32'h8000_0004, 4'hf);
                rd(12'h000);
                chk(rv, {20'h0_0000, lens[i]});
            end
            for (k = 0; k < 300 && tx_engine_busy !== 1'b0; k++) @(posedge clk);
            chk(tx_engine_busy, 1'b0);
            nw = lens[i][11:3] + (lens[i][2:0] != 3'd0);
            chk(64'(mac_stream_model_inst.got_data.size()), 64'(nw));
            for (int w = 0; w < nw && w < mac_stream_model_inst.got_data.size(); w++) begin
                e = {txw(2 * w + 1), (w == 0) ? 32'ha5a5_ff00 : txw(2 * w)};
                chk(mac_stream_model_inst.got_data[w], e);
                e = (w == nw - 1 && lens[i][2:0] != 3'd0) ? 8'hff >> (4'd8 - lens[i][2:0]) : 8'hff;
                chk(mac_stream_model_inst.got_keep[w], e);
                chk(mac_stream_model_inst.got_last[w], w == nw - 1);
            end
            mac_stream_model_inst.got_data.delete();
            mac_stream_model_inst.got_keep.delete();
            mac_stream_model_inst.got_last.delete();
        end
        stall <= 1'b0;
        $display("test_tx done");
    endtask
    task automatic test_rx();
        wr(12'h008, 32'h0000_005a, 4'hf);
        wr(12'h011, 32'h0000_a500, 4'hf);
        wr(12'h004, 32'h0000_0001, 4'hf);
        wr(12'h005, 32'h0000_0020, 4'hf);
        wr(12'h002, 32'h0000_0001, 4'hf);
        repeat (4) @(posedge clk);
        for (int p = 0; p < 17; p++) rx_send(p, 1'b1);
        rd(12'h001);
        chk(rv, 32'h0000_1000);
        rd(12'h800);
        chk(rv, mac_stream_model_inst.pkt(0, 0, 1'b1) & 64'hffff_ffff);
        rd(12'h809);
        chk(rv, mac_stream_model_inst.pkt(0, 4, 1'b1) >> 32);
        for (int p = 0; p < 16; p++) pop_check(5 * (p + 1));
        rx_send(8'h40, 1'b0);
        rx_send(8'h41, 1'b1);
        pop_check(9'd85);
        wr(12'h002, 32'h0000_0000, 4'hf);
        repeat (4) @(posedge clk);
        rx_send(8'h42, 1'b1);
        rd(12'h001);
        chk(rv, 32'h0000_0002);
        wr(12'h004, 32'h0000_0000, 4'hf);
        wr(12'h005, 32'h0000_0000, 4'hf);
        wr(12'h002, 32'h0000_0001, 4'hf);
        repeat (4) @(posedge clk);
        rx_send(8'h43, 1'b0);
        pop_check(9'd90);
        ea = 9'd90;
        for (int p = 0; p < 90; p++) begin
            rx_send(p, 1'b0);
            ea = ea + 9'd5;
            pop_check(ea);
        end
        $display("test_rx done");
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        stall = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0000_0000;
        reg_byte_en = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_tx();
        test_rx();
        complete_run();
    end
endmodule
